// file: include/scoc_params.svh
// Constants of the secondary clock output control block.
// Assumes inclusion by bare name from include/.
`ifndef SCOC_PARAMS_SVH
`define SCOC_PARAMS_SVH
`define SCOC_NUM_CLK 10
`define SCOC_ADDR_W 8
`define SCOC_DATA_W 32
`define SCOC_OFS_CTRL 8'h00
`define SCOC_OFS_PM 8'h04
`define SCOC_OFS_STAT 8'h08
`define SCOC_CTRL_RST 10'h000
`define SCOC_PM_D0 2'h0
`define SCOC_PM_D3HOT 2'h3
`define SCOC_CNT_W 4
`define SCOC_CNT_LAST 4'h9
`define SCOC_STAT_BUSY 10
`define SCOC_STAT_SYNC 11
`define SCOC_STAT_ASYNC 12
`define SCOC_STAT_STOP 13
`endif

// file: include/scoc_pkg.sv
// Types of the secondary clock output control block.
// Assumes scoc_params.svh sits beside it.
package scoc_pkg;
  // Operating mode decoded from the two mode pins
  typedef enum logic [1:0] {
    SCOC_MODE_RSVD,
    SCOC_MODE_SYNC,
    SCOC_MODE_ASYNC
  } scoc_mode_e;
  // Serial mask receiver state
  typedef enum logic {
    SCOC_SH_IDLE,
    SCOC_SH_SHIFT
  } scoc_shift_e;
endpackage : scoc_pkg

// file: core/scoc_gate.sv
// One glitch-free gate for a single secondary clock output.
// Assumes src_level is a clean registered clock level on clk_sys.
`timescale 1ns/10ps
`include "scoc_params.svh"

module scoc_gate (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic src_level,
  input wire logic stop_req,
  input wire logic disable_req,
  output logic clk_out_reg
);
  import scoc_pkg::*;

  logic stop_reg;
  logic dis_reg;
  logic load_ok;

  // Gate may change only while the output is low or about to fall
  assign load_ok = !clk_out_reg || (dis_reg && !src_level); // R15

  // -------------------------------------------------------------
  // Gate state
  // -------------------------------------------------------------
  // Stop and disable requests are taken only at a safe level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stop_reg <= 1'b1;
      dis_reg <= 1'b0;
    end else if (load_ok) begin // R15
      stop_reg <= stop_req;
      dis_reg <= disable_req;
    end
  end

  // Output: stopped low, disabled static high, else the source
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_out_reg <= 1'b0;
    end else if (stop_reg) begin
      clk_out_reg <= 1'b0; // R10
    end else if (dis_reg) begin
      clk_out_reg <= 1'b1; // R7
    end else begin
      clk_out_reg <= src_level;
    end
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  chk_stop_goes_low: assert property ( // R10
    @(posedge clk_sys) disable iff (!nrst)
    (!clk_out_reg && stop_req) |=> ##1 !clk_out_reg)
  else $error("stopped clock output did not stay low");

  chk_gate_safe_change: assert property ( // R15
    @(posedge clk_sys) disable iff (!nrst)
    ($changed(dis_reg) || $changed(stop_reg)) |->
      (!$past(clk_out_reg) || !$past(src_level)))
  else $error("clock gate changed while output high");
endmodule : scoc_gate

// file: core/scoc_top.sv
// Secondary clock output control: makes, gates and stops the
// secondary clocks of a bridge, and takes a serial disable mask.
// Assumes all pins are synchronous to clk_sys, which stands for
// the primary clock; software uses a plain register port.
`timescale 1ns/10ps
`include "scoc_params.svh"

// Behaviour
// [R1] Primary-side timing comes from the primary clock, secondary-side timing from the fed-back secondary clock.
// [R2] In synchronous mode all ten outputs are made in phase with the primary clock.
// [R3] Per-output disable bits in the control register switch single outputs off.
// [R4] A serial disable mask on the mask pin, driven by outside logic, also switches outputs off.
// [R5] Mask reception starts when primary reset is seen released while secondary reset is still asserted.
// [R6] Each mask bit is shifted into the control register and then disables its output.
// [R7] A mask held low leaves all outputs running; a mask held high holds all outputs high.
// [R8] The shared pin is the mask input in synchronous mode and the source clock in asynchronous mode.
// [R9] In asynchronous mode the outputs come from the asynchronous source clock.
// [R10] With clock stop enable high, D3hot stops all outputs and holds them at 0.
// [R11] With clock stop enable low, D3hot leaves the outputs untouched.
// [R12] Mode pins 1 0 give synchronous mode, 1 1 asynchronous, the rest are reserved.
// [R13] In asynchronous mode a low rate select halves the source clock.
// [R14] In asynchronous mode a high rate select passes the source clock unchanged.
// [R15] The mask is taken one bit per cycle, and gates switch only while low; a disabled gate also switches while high if its source is low.
module scoc_top #(
  parameter int NUM_CLK = `SCOC_NUM_CLK,
  parameter int ASYNC_DRIVEN = `SCOC_NUM_CLK
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`SCOC_ADDR_W-1:0] reg_addr,
  input wire logic [`SCOC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SCOC_DATA_W-1:0] reg_rdata,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic clock_rate_select,
  input wire logic clock_mask_serial_in,
  input wire logic bus_power_clock_stop_enable,
  input wire logic primary_reset_n,
  input wire logic secondary_reset_n,
  input wire logic secondary_clock_feedback_in,
  output logic secondary_bus_tick,
  output logic [NUM_CLK-1:0] secondary_clock_outputs
);
  import scoc_pkg::*;

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  scoc_mode_e mode;
  scoc_shift_e shift_reg;
  scoc_shift_e shift_next;
  logic [NUM_CLK-1:0] ctrl_reg;
  logic [1:0] pm_reg;
  logic [`SCOC_CNT_W-1:0] cnt_reg;
  logic prst_reg;
  logic ref_reg;
  logic async_lvl_reg;
  logic half_reg;
  logic fb_reg;
  logic shift_start;
  logic shift_done;
  logic power_stop;
  logic mask_pin;
  logic async_pin;
  logic sync_src;
  logic async_src;
  logic [NUM_CLK-1:0] out_stop;
  logic [`SCOC_DATA_W-1:0] rd_mux;

  // -------------------------------------------------------------
  // Mode and shared pin
  // -------------------------------------------------------------
  // Decode mode pins; reserved patterns stop every output
  always_comb begin
    case ({mode_select_a, mode_select_b})
      2'h2: mode = SCOC_MODE_SYNC; // R12
      2'h3: mode = SCOC_MODE_ASYNC; // R12
      default: mode = SCOC_MODE_RSVD;
    endcase
  end

  // Shared pin serves one role per mode
  assign mask_pin = (mode == SCOC_MODE_SYNC) &
    clock_mask_serial_in; // R8
  assign async_pin = (mode == SCOC_MODE_ASYNC) &
    clock_mask_serial_in; // R8

  // -------------------------------------------------------------
  // Clock sources
  // -------------------------------------------------------------
  // Reference level that follows the primary clock phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_reg <= 1'b0;
    end else begin
      ref_reg <= ~ref_reg; // R2
    end
  end

  // Asynchronous source level and its half-rate copy
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      async_lvl_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      async_lvl_reg <= async_pin; // R9
      if (async_pin && !async_lvl_reg) begin
        half_reg <= ~half_reg; // R13
      end
    end
  end

  // Source select for each mode and rate
  assign sync_src = ref_reg; // R2
  assign async_src = clock_rate_select ? async_lvl_reg // R14
    : half_reg; // R13

  // -------------------------------------------------------------
  // Secondary-side timing from the fed-back clock
  // -------------------------------------------------------------
  // One-cycle tick on each rising edge of the feedback clock
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fb_reg <= 1'b0;
      secondary_bus_tick <= 1'b0;
    end else begin
      fb_reg <= secondary_clock_feedback_in;
      secondary_bus_tick <= secondary_clock_feedback_in
        & ~fb_reg; // R1
    end
  end

  // -------------------------------------------------------------
  // Serial mask receiver
  // -------------------------------------------------------------
  // Primary reset release seen while secondary reset still held
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prst_reg <= 1'b1; // Idles released: no false release after reset
    end else begin
      prst_reg <= primary_reset_n;
    end
  end

  assign shift_start = primary_reset_n & ~prst_reg &
    ~secondary_reset_n & (mode == SCOC_MODE_SYNC) &
    (shift_reg == SCOC_SH_IDLE); // R5
  assign shift_done = (shift_reg == SCOC_SH_SHIFT) &
    (cnt_reg == `SCOC_CNT_LAST);

  // Next state of the receiver
  always_comb begin
    case (shift_reg)
      SCOC_SH_IDLE: shift_next = shift_start ? SCOC_SH_SHIFT
        : SCOC_SH_IDLE;
      SCOC_SH_SHIFT: shift_next = shift_done ? SCOC_SH_IDLE
        : SCOC_SH_SHIFT;
      default: shift_next = SCOC_SH_IDLE;
    endcase
  end

  // State and bit counter, one mask bit per cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= SCOC_SH_IDLE;
      cnt_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      if (shift_reg == SCOC_SH_SHIFT) begin
        cnt_reg <= cnt_reg + 1'b1; // R15
      end else begin
        cnt_reg <= '0;
      end
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  // Control: disable bits, loaded by software or by the mask
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `SCOC_CTRL_RST;
    end else if (shift_reg == SCOC_SH_SHIFT) begin
      ctrl_reg <= {mask_pin, ctrl_reg[NUM_CLK-1:1]}; // R6
    end else if (reg_wr && reg_addr == `SCOC_OFS_CTRL) begin
      ctrl_reg <= reg_wdata[NUM_CLK-1:0]; // R3
    end
  end

  // Power state field
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pm_reg <= `SCOC_PM_D0;
    end else if (reg_wr && reg_addr == `SCOC_OFS_PM) begin
      pm_reg <= reg_wdata[1:0];
    end
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      `SCOC_OFS_CTRL: rd_mux[NUM_CLK-1:0] = ctrl_reg;
      `SCOC_OFS_PM: rd_mux[1:0] = pm_reg;
      `SCOC_OFS_STAT: begin
        rd_mux[NUM_CLK-1:0] = secondary_clock_outputs;
        rd_mux[`SCOC_STAT_BUSY] = (shift_reg == SCOC_SH_SHIFT);
        rd_mux[`SCOC_STAT_SYNC] = (mode == SCOC_MODE_SYNC);
        rd_mux[`SCOC_STAT_ASYNC] = (mode == SCOC_MODE_ASYNC);
        rd_mux[`SCOC_STAT_STOP] = power_stop;
      end
      default: rd_mux = '0;
    endcase
  end

  // Read data stand for the one cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= '0;
    end
  end

  // -------------------------------------------------------------
  // Output gates
  // -------------------------------------------------------------
  // D3hot stops the clocks only with the stop enable high
  assign power_stop = bus_power_clock_stop_enable & // R10
    (pm_reg == `SCOC_PM_D3HOT); // R11

  // One gate per output; async mode drives only outputs below ASYNC_DRIVEN
  for (genvar i = 0; i < NUM_CLK; i++) begin : g_out
    assign out_stop[i] = power_stop | (mode == SCOC_MODE_RSVD) |
      ((mode == SCOC_MODE_ASYNC) && (i >= ASYNC_DRIVEN));
    scoc_gate u_gate (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .src_level((mode == SCOC_MODE_ASYNC) ? async_src // R9
        : sync_src), // R2
      .stop_req(out_stop[i]),
      .disable_req(ctrl_reg[i]), // R4
      .clk_out_reg(secondary_clock_outputs[i])
    );
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_mask_start;
    shift_start;
  endsequence

  sequence s_sync_steady;
    (mode == SCOC_MODE_SYNC && ctrl_reg == '0 && !power_stop)[*3];
  endsequence

  sequence s_d3_stop;
    power_stop[*2];
  endsequence

  sequence s_d3_kept;
    (pm_reg == `SCOC_PM_D3HOT && !bus_power_clock_stop_enable &&
      mode == SCOC_MODE_SYNC && $stable(ctrl_reg))[*6];
  endsequence

  chk_mask_start_busy: assert property ( // R5
    s_mask_start |=> shift_reg == SCOC_SH_SHIFT)
  else $error("mask reception did not start");

  chk_mask_bit_count: assert property ( // R15
    s_mask_start |-> ##10 shift_reg == SCOC_SH_SHIFT ##1
      shift_reg == SCOC_SH_IDLE)
  else $error("mask reception length wrong");

  chk_mask_shift_in: assert property ( // R6
    shift_reg == SCOC_SH_SHIFT |=>
      ctrl_reg[NUM_CLK-1] == $past(mask_pin))
  else $error("mask bit not shifted into control");

  chk_mask_all_high: assert property ( // R7
    (s_mask_start ##1 mask_pin[*8] ##1 mask_pin ##1 mask_pin)
      |=> ctrl_reg == '1)
  else $error("high mask did not disable all outputs");

  chk_sync_phase: assert property ( // R2
    s_sync_steady ##1 s_sync_steady |->
      secondary_clock_outputs[0] == $past(ref_reg))
  else $error("sync output not following reference");

  chk_d3_clock_stop: assert property ( // R10
    s_d3_stop |-> ##[1:4] secondary_clock_outputs == '0)
  else $error("clocks not stopped in D3hot");

  chk_d3_no_effect: assert property ( // R11
    s_d3_kept |->
      (secondary_clock_outputs ^ $past(secondary_clock_outputs)) ==
        ~ctrl_reg)
  else $error("D3hot changed clocks with stop disabled");

  chk_mode_decode: assert property ( // R12
    (reg_rd && reg_addr == `SCOC_OFS_STAT) |=>
      (reg_rdata[`SCOC_STAT_SYNC] ==
        ($past(mode_select_a) && !$past(mode_select_b))) &&
      (reg_rdata[`SCOC_STAT_ASYNC] ==
        ($past(mode_select_a) && $past(mode_select_b))))
  else $error("mode pins decoded wrong");

  chk_async_half: assert property ( // R13
    (mode == SCOC_MODE_ASYNC && async_pin && !async_lvl_reg)
      |=> half_reg != $past(half_reg))
  else $error("half rate source did not toggle");

  chk_read_data: assert property ( // R3
    (reg_rd && reg_addr == `SCOC_OFS_CTRL) |=>
      reg_rdata[NUM_CLK-1:0] == $past(ctrl_reg))
  else $error("control read back wrong");
endmodule : scoc_top

// file: testbench/scoc_sec_dev.sv
// Model of the secondary side: mask source on the shared pin and the
// fed-back clock. Assumes its pins are sampled on clk_sys rising edges.
`timescale 1ns/10ps

module scoc_sec_dev (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic primary_reset_n,
  input wire logic secondary_reset_n,
  input wire logic [9:0] mask_value,
  input wire logic [9:0] clk_in,
  output logic mask_out,
  output logic clk_fb
);
  logic prst_d_reg;
  logic [3:0] bit_cnt_reg;
  // Output 0 is routed back as the secondary clock input
  assign clk_fb = clk_in[0];
  // Primary reset level seen at the last edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prst_d_reg <= 1'b1;
    end else begin
      prst_d_reg <= primary_reset_n;
    end
  end
  // One mask bit per edge, first bit first; pin idles low (pull-down)
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg <= 4'h0;
      mask_out <= 1'b0;
    end else if (bit_cnt_reg == 4'h0 && !prst_d_reg && primary_reset_n &&
                 !secondary_reset_n) begin
      bit_cnt_reg <= 4'h1;
      mask_out <= mask_value[0];
    end else if (bit_cnt_reg != 4'h0 && bit_cnt_reg < 4'ha) begin
      mask_out <= mask_value[bit_cnt_reg];
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else begin
      bit_cnt_reg <= 4'h0;
      mask_out <= 1'b0;
    end
  end
endmodule : scoc_sec_dev

// file: testbench/tb.sv
// Self-checking bench for the secondary clock output control block.
// Assumes scoc_top, scoc_sec_dev and the shared constants are compiled.
`timescale 1ns/10ps
`include "scoc_params.svh"

module tb;
  import scoc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [`SCOC_ADDR_W-1:0] reg_addr = '0;
  logic [`SCOC_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`SCOC_DATA_W-1:0] reg_rdata;
  logic ms_a = 1'b1;
  logic ms_b = 1'b0;
  logic rate_sel = 1'b1;
  logic stop_en = 1'b0;
  logic prst_n = 1'b1;
  logic srst_n = 1'b1;
  logic async_on = 1'b0;
  logic aclk = 1'b0;
  logic mask_pin, pin, fb, tick;
  logic [9:0] mask_val = '0;
  logic [`SCOC_NUM_CLK-1:0] clk_out;
  logic [31:0] lfsr = 32'h0000_21f3;
  logic [31:0] rd;
  int err_count = 0;
  int n_compared = 0;
  int ctrl_m = 0;
  int pm_m = 0;
  int acnt = 0;
  int cnt [10];
  int pin_cnt, fb_cnt, tick_cnt, kind, ek;
  // Shared pin: mask stream in sync mode, source clock in async mode
  assign pin = async_on ? aclk : mask_pin;
  scoc_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_select_a(ms_a), .mode_select_b(ms_b),
    .clock_rate_select(rate_sel), .clock_mask_serial_in(pin),
    .bus_power_clock_stop_enable(stop_en), .primary_reset_n(prst_n),
    .secondary_reset_n(srst_n), .secondary_clock_feedback_in(fb),
    .secondary_bus_tick(tick), .secondary_clock_outputs(clk_out));
  scoc_sec_dev u_sec (.clk_sys(clk_sys), .nrst(nrst),
    .primary_reset_n(prst_n), .secondary_reset_n(srst_n),
    .mask_value(mask_val), .clk_in(clk_out), .mask_out(mask_pin),
    .clk_fb(fb));
  // 100 ns system clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Source clock for async mode, toggling every third cycle
  always @(posedge clk_sys) begin
    acnt <= (acnt == 2) ? 0 : acnt + 1;
    if (acnt == 2) aclk <= ~aclk;
  end
  // ----------------------------------------------------------------
  // Bus tasks, model and compares
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr_next
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_read
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t register got %h want %h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_cnt(input int got, input int exp);
    n_compared++;
    if (got < exp - 1 || got > exp + 1) begin
      err_count++;
      $display("FAIL %0t edge count got %0d want %0d", $time, got, exp);
    end
  endtask : check_cnt
  // Count output, pin, feedback and tick activity over n cycles
  task automatic count_act(input int n);
    logic [9:0] prev;
    logic pp, fp;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    prev = clk_out;
    pp = pin;
    fp = fb;
    cnt = '{default: 0};
    pin_cnt = 0;
    fb_cnt = 0;
    tick_cnt = 0;
    repeat (n) begin
      @(negedge clk_sys);
      for (int k = 0; k < 10; k++) if (clk_out[k] !== prev[k]) cnt[k]++;
      if (pin !== pp) pin_cnt++;
      if (fb === 1'b1 && fp === 1'b0) fb_cnt++;
      if (tick === 1'b1) tick_cnt++;
      prev = clk_out;
      pp = pin;
      fp = fb;
    end
  endtask : count_act
  // Kind of each sync output: 0 running, 1 static high, 2 static low
  task automatic check_clk();
    count_act(8);
    for (int i = 0; i < 10; i++) begin
      kind = (cnt[i] == 8) ? 0 : (cnt[i] != 0) ? 3 :
             (clk_out[i] === 1'b1) ? 1 : (clk_out[i] === 1'b0) ? 2 : 3;
      ek = (!ms_a || (pm_m == 3 && stop_en)) ? 2 : ctrl_m[i] ? 1 : 0;
      n_compared++;
      if (kind != ek) begin
        err_count++;
        $display("FAIL %0t output %0d kind %0d want %0d", $time, i, kind, ek);
      end
    end
  endtask : check_clk
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Watchdog on the whole run
  initial begin
    #(100 * 6000);
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    stop_test();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    reg_read(`SCOC_OFS_CTRL, rd);
    check_reg(rd, 32'h0000_0000);
    reg_read(`SCOC_OFS_PM, rd);
    check_reg(rd, 32'h0000_0000);
    reg_read(8'h0c, rd);
    check_reg(rd, 32'h0000_0000);
    $display("test reset done");
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      ctrl_m = int'(lfsr[9:0]);
      reg_write(`SCOC_OFS_CTRL, 32'(ctrl_m));
      reg_read(`SCOC_OFS_CTRL, rd);
      check_reg(rd, 32'(ctrl_m));
      check_clk();
    end
    $display("test disable bits done");
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_sys);
      stop_en <= 1'(e);
      pm_m = 3;
      reg_write(`SCOC_OFS_PM, 32'h0000_0003);
      check_clk();
      reg_read(`SCOC_OFS_STAT, rd);
      check_reg(32'(rd[`SCOC_STAT_STOP]), 32'(e));
      pm_m = 0;
      reg_write(`SCOC_OFS_PM, 32'h0000_0000);
    end
    $display("test power stop done");
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys);
      ms_a <= (m == 2);
      ms_b <= (m == 1);
      check_clk();
      reg_read(`SCOC_OFS_STAT, rd);
      check_reg(32'(rd[`SCOC_STAT_ASYNC:`SCOC_STAT_SYNC]),
        (m == 2) ? 32'h0000_0001 : 32'h0000_0000);
    end
    $display("test mode pins done");
    for (int m = 0; m < 3; m++) begin
      lfsr = lfsr_next(lfsr);
      mask_val = (m == 0) ? lfsr[9:0] : (m == 1) ? 10'h000 : 10'h3ff;
      @(posedge clk_sys);
      srst_n <= 1'b0;
      prst_n <= 1'b0;
      @(posedge clk_sys);
      prst_n <= 1'b1;
      reg_read(`SCOC_OFS_STAT, rd);
      check_reg(32'(rd[`SCOC_STAT_BUSY]), 32'h0000_0001);
      repeat (12) @(posedge clk_sys);
      reg_read(`SCOC_OFS_CTRL, rd);
      check_reg(rd, 32'(mask_val));
      ctrl_m = int'(mask_val);
      check_clk();
      @(posedge clk_sys);
      srst_n <= 1'b1;
    end
    $display("test serial mask done");
    ctrl_m = 0;
    reg_write(`SCOC_OFS_CTRL, 32'h0000_0000);
    count_act(40);
    check_cnt(tick_cnt, fb_cnt);
    $display("test feedback tick done");
    @(posedge clk_sys);
    ms_b <= 1'b1;
    async_on <= 1'b1;
    for (int r = 1; r >= 0; r--) begin
      @(posedge clk_sys);
      rate_sel <= 1'(r);
      count_act(60);
      for (int k = 0; k < 10; k++) begin
        check_cnt(cnt[k], r ? pin_cnt : pin_cnt / 2);
      end
    end
    $display("test async clocks done");
    stop_test();
  end
endmodule : tb
